// file: lsst_pkg.sv
// How it works
// [R1] Controller pixel clock stays within 1-50 MHz.
// [R2] Sensor outputs one pixel per clock.
// [R3] Scan cycle spans 58 clocks to 100 ms.
// [R4] Start pulse high at least 6 clocks.
// [R5] Start pulse low at least 52 clocks.
// [R6] Integration lasts exactly the start high time.
// [R7] High/low split sets integration; sensor honours it.
// [R8] Shifting starts first clock rise after fall.
// [R9] Pixels sampled on trigger strobe falling edge.
// [R10] First pixel on falling edge of pulse 49.
// [R11] Full 512-pixel readout needs 564-clock cycle.
// [R12] Partial 32-pixel readout allows 79-clock cycle.
// [R13] All 512 pixels integrate in one window.
// [R14] Sensor timing needs only start and clock.
// [R15] Sensor drives the trigger strobe output.
// [R16] Controller counts clock rises for pulse timing.
// [R17] Sensor pulses end-of-scan once after last pixel.
package lsst_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock rates.
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int PIX_DIV    = 2;
    localparam int PIX_CLK_HZ = SYS_CLK_HZ / PIX_DIV;
    localparam int CLK_MIN_HZ = 1_000_000;
    localparam int CLK_MAX_HZ = 50_000_000;

    ////////////////////////////////////////////////////////////////////////
    // Widths.
    localparam int CNT_W   = 24;
    localparam int STEP_W  = 10;
    localparam int VIDEO_W = 12;
    localparam int INDEX_W = 9;

    ////////////////////////////////////////////////////////////////////////
    // Scan geometry, counted in pixel clock periods.
    localparam logic [STEP_W-1:0] PIXELS         = 10'h200;
    localparam logic [STEP_W-1:0] PARTIAL_PIXELS = 10'h020;
    localparam logic [STEP_W-1:0] FIRST_PIX_TRIG = 10'h031;
    localparam logic [STEP_W-1:0] LAST_TRIG      = FIRST_PIX_TRIG + PIXELS
                                                   - 10'h001;
    localparam logic [STEP_W-1:0] END_STEP       = LAST_TRIG + 10'h001;
    localparam logic [CNT_W-1:0]  MIN_HIGH       = 24'h000006;
    localparam logic [CNT_W-1:0]  MIN_LOW        = 24'h000034;
    localparam logic [CNT_W-1:0]  MIN_CYCLE      = 24'h00003a;
    localparam logic [CNT_W-1:0]  FULL_CYCLE     = 24'h000234;
    localparam logic [CNT_W-1:0]  PARTIAL_CYCLE  = 24'h00004f;

    ////////////////////////////////////////////////////////////////////////
    // Longest scan cycle: 100 ms expressed in pixel clocks.
    localparam int MAX_CYCLE_MS = 100;
    localparam logic [CNT_W-1:0] MAX_CYCLE_CLKS =
        CNT_W'((PIX_CLK_HZ / 1000) * MAX_CYCLE_MS);

    ////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [VIDEO_W-1:0] VIDEO_RST = 12'h000;
    localparam logic [CNT_W-1:0]   CNT_RST   = 24'h000000;

endpackage

// file: lsst_link_if.sv
`timescale 1ns/1ps
// Pins between the timing controller and the sensor.
interface lsst_link_if;
    logic                         scanStart;
    logic                         pixClk;
    logic                         trigStrobe;
    logic [lsst_pkg::VIDEO_W-1:0] video;
    logic                         scanEnd;

    modport sensor (
        input  scanStart,
        input  pixClk,
        output trigStrobe,
        output video,
        output scanEnd
    );

    modport controller (
        output scanStart,
        output pixClk,
        input  trigStrobe,
        input  video,
        input  scanEnd
    );
endinterface

// file: lsst_step_counter.sv
`timescale 1ns/1ps
// Clearable up-counter that saturates at its all-ones value.
module lsst_step_counter #(
    parameter int W = 10
) (
    // Clock and reset.
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // Control.
    input  wire logic         clr,
    input  wire logic         inc,
    // State.
    output logic      [W-1:0] count
);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;

    // Clear wins over increment so a new scan always starts from zero.
    always_comb begin
        count_nxt = count_r;
        if (clr) begin
            count_nxt = '0;
        end else if (inc && (count_r != '1)) begin
            count_nxt = count_r + W'(1);
        end
    end

    // Register stage.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count = count_r;
endmodule

// file: lsst_sensor.sv
`timescale 1ns/1ps
// Linear sensor end: integrates while start is high, then reads out.
module lsst_sensor (
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Link to the controller.
    lsst_link_if.sensor link
);
    typedef enum logic [1:0] {SENS_IDLE, SENS_INTEG, SENS_READ} lsst_sens_e;

    lsst_sens_e                   state_r, state_nxt;
    logic [lsst_pkg::CNT_W-1:0]   expo_r, expo_nxt;
    logic [lsst_pkg::CNT_W-1:0]   frameExp_r, frameExp_nxt;
    logic                         pixClkPrev_r;
    logic                         trig_r, trig_nxt;
    logic [lsst_pkg::VIDEO_W-1:0] video_r, video_nxt;
    logic                         scanEnd_r, scanEnd_nxt;
    logic [lsst_pkg::STEP_W-1:0]  step;
    logic [lsst_pkg::STEP_W-1:0]  nextStep;
    logic                         pixRise;
    logic                         pixFall;

    // Stand-in pixel response: exposure times a per-pixel gain, clipped.
    function automatic logic [lsst_pkg::VIDEO_W-1:0] pixelLevel(
        input logic [lsst_pkg::CNT_W-1:0]  expo,
        input logic [lsst_pkg::STEP_W-1:0] idx
    );
        logic [lsst_pkg::CNT_W+4:0] prod;
        prod = {5'h00, expo} * {24'h000000, 1'b1, idx[3:0]};
        if (prod > {17'h00000, {lsst_pkg::VIDEO_W{1'b1}}}) begin
            return '1;
        end
        return prod[lsst_pkg::VIDEO_W-1:0];
    endfunction

    assign pixRise  = link.pixClk && !pixClkPrev_r;
    assign pixFall  = !link.pixClk && pixClkPrev_r;
    assign nextStep = step + 10'h001;

    ////////////////////////////////////////////////////////////////////////
    // Readout step counter, counting clock rises since start fell.
    lsst_step_counter #(.W(lsst_pkg::STEP_W)) u_step (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clr     (state_r != SENS_READ),
        .inc     ((state_r == SENS_READ) && pixRise), // [R8] [R2]
        .count   (step)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state. Only start and the clock steer the sequence. [R14]
    always_comb begin
        state_nxt    = state_r;
        expo_nxt     = expo_r;
        frameExp_nxt = frameExp_r;
        trig_nxt     = trig_r;
        video_nxt    = video_r;
        scanEnd_nxt  = scanEnd_r;
        if (pixFall) begin
            trig_nxt = 1'b0; // [R15]
        end
        if (link.scanStart) begin
            // One shared exposure counter serves every pixel alike. [R13]
            trig_nxt    = 1'b0;
            scanEnd_nxt = 1'b0;
            if (state_r != SENS_INTEG) begin
                state_nxt = SENS_INTEG;
                expo_nxt  = lsst_pkg::CNT_RST;
            end else if (pixRise && (expo_r != '1)) begin
                expo_nxt = expo_r + 24'h000001; // [R6]
            end
        end else if (state_r == SENS_INTEG) begin
            // Start fell: freeze the exposure of the whole line at once.
            frameExp_nxt = expo_r; // [R6] [R7] [R13]
            state_nxt    = SENS_READ;
        end else if ((state_r == SENS_READ) && pixRise) begin
            // Video changes on the rise so it is settled at the strobe fall.
            trig_nxt    = (nextStep <= lsst_pkg::LAST_TRIG); // [R15] [R9]
            scanEnd_nxt = (nextStep == lsst_pkg::END_STEP); // [R17]
            if ((nextStep >= lsst_pkg::FIRST_PIX_TRIG) &&
                (nextStep <= lsst_pkg::LAST_TRIG)) begin
                video_nxt = pixelLevel(frameExp_r,
                    nextStep - lsst_pkg::FIRST_PIX_TRIG); // [R10] [R2]
            end
        end
    end

    // Register stage.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r      <= SENS_IDLE;
            expo_r       <= lsst_pkg::CNT_RST;
            frameExp_r   <= lsst_pkg::CNT_RST;
            pixClkPrev_r <= 1'b0;
            trig_r       <= 1'b0;
            video_r      <= lsst_pkg::VIDEO_RST;
            scanEnd_r    <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            expo_r       <= expo_nxt;
            frameExp_r   <= frameExp_nxt;
            pixClkPrev_r <= link.pixClk;
            trig_r       <= trig_nxt;
            video_r      <= video_nxt;
            scanEnd_r    <= scanEnd_nxt;
        end
    end

    // Pin drivers, straight from flip-flops.
    assign link.trigStrobe = trig_r;
    assign link.video      = video_r;
    assign link.scanEnd    = scanEnd_r;
endmodule

// file: lsst_controller.sv
`timescale 1ns/1ps
// Timing controller end: makes the pixel clock and start pulse and
// samples the video on each trigger strobe falling edge from fall 49 to pixel 512, or to pixel 32 in partial mode.
module lsst_controller #(
    parameter logic [lsst_pkg::CNT_W-1:0] MAX_CYCLE = lsst_pkg::MAX_CYCLE_CLKS
) (
    // Clock and reset.
    input  wire logic                         sys_clk,
    input  wire logic                         rst_n,
    // Scan configuration, in pixel clock periods.
    input  wire logic                         runEn,
    input  wire logic                         partialMode,
    input  wire logic [lsst_pkg::CNT_W-1:0]   integReq,
    input  wire logic [lsst_pkg::CNT_W-1:0]   cycleReq,
    // Captured pixels.
    output logic      [lsst_pkg::VIDEO_W-1:0] pixData,
    output logic      [lsst_pkg::INDEX_W-1:0] pixIndex,
    output logic                              pixValid,
    output logic                              frameDone,
    // Status.
    output logic                              scanActive,
    // Link to the sensor.
    lsst_link_if.controller                   link
);
    typedef enum logic {CTRL_IDLE, CTRL_RUN} lsst_ctrl_e;

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    lsst_ctrl_e                   state_r, state_nxt;
    logic                         pixClk_r, pixClk_nxt;
    logic                         start_r, start_nxt;
    logic [lsst_pkg::CNT_W-1:0]   phase_r, phase_nxt;
    logic [lsst_pkg::CNT_W-1:0]   highLen_r, highLen_nxt;
    logic [lsst_pkg::CNT_W-1:0]   cycleLen_r, cycleLen_nxt;
    logic                         partial_r, partial_nxt;
    logic [lsst_pkg::CNT_W-1:0]   cfgHigh;
    logic [lsst_pkg::CNT_W-1:0]   cfgCycle;
    logic                         pixRise;
    logic                         pixFall;
    logic                         cycleEnd;

    logic                         trigPrev_r;
    logic                         trigFall;
    logic [lsst_pkg::STEP_W-1:0]  trigCount;
    logic [lsst_pkg::STEP_W-1:0]  trigNow;
    logic [lsst_pkg::STEP_W-1:0]  pixLimit;
    logic [lsst_pkg::STEP_W-1:0]  pixOffset;
    logic [lsst_pkg::VIDEO_W-1:0] pixData_r, pixData_nxt;
    logic [lsst_pkg::INDEX_W-1:0] pixIndex_r, pixIndex_nxt;
    logic                         pixValid_r, pixValid_nxt;
    logic                         frameDone_r, frameDone_nxt;
    logic                         scanActive_r, scanActive_nxt;

    // Larger of two counts.
    function automatic logic [lsst_pkg::CNT_W-1:0] maxOf(
        input logic [lsst_pkg::CNT_W-1:0] a,
        input logic [lsst_pkg::CNT_W-1:0] b
    );
        return (a > b) ? a : b;
    endfunction

    // Smaller of two counts.
    function automatic logic [lsst_pkg::CNT_W-1:0] minOf(
        input logic [lsst_pkg::CNT_W-1:0] a,
        input logic [lsst_pkg::CNT_W-1:0] b
    );
        return (a < b) ? a : b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pixel clock: system clock divided by two gives 50 MHz, the top of
    // the permitted range. A faster system clock needs a larger divider.
    assign pixRise = !pixClk_r; // [R1]
    assign pixFall = pixClk_r;

    ////////////////////////////////////////////////////////////////////////
    // Legalise the requested split. High and cycle are raised to their
    // floors first; the cycle ceiling then trims the high time, since the
    // low time may never shrink below its floor.
    always_comb begin
        cfgHigh  = maxOf(integReq, lsst_pkg::MIN_HIGH); // [R4]
        cfgCycle = maxOf(cycleReq, lsst_pkg::MIN_CYCLE); // [R3]
        if (partialMode) begin
            cfgCycle = maxOf(cfgCycle, lsst_pkg::PARTIAL_CYCLE); // [R12]
        end else begin
            cfgCycle = maxOf(cfgCycle, lsst_pkg::FULL_CYCLE); // [R11]
        end
        cfgCycle = maxOf(cfgCycle, cfgHigh + lsst_pkg::MIN_LOW); // [R5] [R7]
        cfgCycle = minOf(cfgCycle, MAX_CYCLE); // [R3]
        cfgHigh  = minOf(cfgHigh, cfgCycle - lsst_pkg::MIN_LOW); // [R5]
    end

    assign cycleEnd = (phase_r == cycleLen_r - 24'h000001);

    ////////////////////////////////////////////////////////////////////////
    // Start pulse sequencer. The phase counts pixel clock rises and the
    // start level changes on clock falls, half a period clear of the
    // edge the sensor acts on. Settings are taken only at a cycle
    // boundary so a change mid-scan never breaks a running cycle.
    always_comb begin
        state_nxt    = state_r;
        pixClk_nxt   = !pixClk_r;
        start_nxt    = start_r;
        phase_nxt    = phase_r;
        highLen_nxt  = highLen_r;
        cycleLen_nxt = cycleLen_r;
        partial_nxt  = partial_r;
        case (state_r)
            CTRL_IDLE: begin
                start_nxt = 1'b0;
                if (runEn && pixRise) begin
                    state_nxt    = CTRL_RUN;
                    phase_nxt    = lsst_pkg::CNT_RST;
                    highLen_nxt  = cfgHigh;
                    cycleLen_nxt = cfgCycle;
                    partial_nxt  = partialMode;
                end
            end
            CTRL_RUN: begin
                if (pixFall) begin
                    start_nxt = (phase_r < highLen_r); // [R16] [R7]
                end
                if (pixRise) begin
                    if (cycleEnd) begin
                        phase_nxt    = lsst_pkg::CNT_RST;
                        highLen_nxt  = cfgHigh;
                        cycleLen_nxt = cfgCycle;
                        partial_nxt  = partialMode;
                        if (!runEn) begin
                            state_nxt = CTRL_IDLE;
                        end
                    end else begin
                        phase_nxt = phase_r + 24'h000001; // [R16]
                    end
                end
            end
            default: begin
                state_nxt = CTRL_IDLE;
                start_nxt = 1'b0;
            end
        endcase
    end

    // Register stage for the sequencer.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= CTRL_IDLE;
            pixClk_r   <= 1'b0;
            start_r    <= 1'b0;
            phase_r    <= lsst_pkg::CNT_RST;
            highLen_r  <= lsst_pkg::MIN_HIGH;
            cycleLen_r <= lsst_pkg::FULL_CYCLE;
            partial_r  <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            pixClk_r   <= pixClk_nxt;
            start_r    <= start_nxt;
            phase_r    <= phase_nxt;
            highLen_r  <= highLen_nxt;
            cycleLen_r <= cycleLen_nxt;
            partial_r  <= partial_nxt;
        end
    end

    assign link.pixClk    = pixClk_r;
    assign link.scanStart = start_r;

    ////////////////////////////////////////////////////////////////////////
    // Strobe counter: falls of the trigger strobe since start fell.
    assign trigFall = trigPrev_r && !link.trigStrobe; // [R9]

    lsst_step_counter #(.W(lsst_pkg::STEP_W)) u_trig (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clr     (start_r),
        .inc     (trigFall),
        .count   (trigCount)
    );

    assign trigNow   = trigCount + 10'h001;
    assign pixOffset = trigNow - lsst_pkg::FIRST_PIX_TRIG;
    assign pixLimit  = partial_r ? lsst_pkg::PARTIAL_PIXELS
                                 : lsst_pkg::PIXELS;

    ////////////////////////////////////////////////////////////////////////
    // Sampler. The video word is taken on the strobe fall, where the
    // sensor holds it steady; the first pixel comes with fall 49.
    always_comb begin
        pixData_nxt    = pixData_r;
        pixIndex_nxt   = pixIndex_r;
        pixValid_nxt   = 1'b0;
        frameDone_nxt  = 1'b0;
        scanActive_nxt = start_r;
        if (!start_r) begin
            scanActive_nxt = scanActive_r;
        end
        if (start_r) begin
            scanActive_nxt = 1'b0;
        end else if (trigFall && (trigNow >= lsst_pkg::FIRST_PIX_TRIG)
                     && (pixOffset < pixLimit)) begin
            pixData_nxt    = link.video; // [R9] [R10]
            pixIndex_nxt   = pixOffset[lsst_pkg::INDEX_W-1:0]; // [R10]
            pixValid_nxt   = 1'b1;
            scanActive_nxt = 1'b1;
            if (pixOffset == pixLimit - 10'h001) begin
                frameDone_nxt  = 1'b1;
                scanActive_nxt = 1'b0;
            end
        end
    end

    // Register stage for the sampler.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            trigPrev_r   <= 1'b0;
            pixData_r    <= lsst_pkg::VIDEO_RST;
            pixIndex_r   <= '0;
            pixValid_r   <= 1'b0;
            frameDone_r  <= 1'b0;
            scanActive_r <= 1'b0;
        end else begin
            trigPrev_r   <= link.trigStrobe;
            pixData_r    <= pixData_nxt;
            pixIndex_r   <= pixIndex_nxt;
            pixValid_r   <= pixValid_nxt;
            frameDone_r  <= frameDone_nxt;
            scanActive_r <= scanActive_nxt;
        end
    end

    // User-side outputs, straight from flip-flops.
    assign pixData    = pixData_r;
    assign pixIndex   = pixIndex_r;
    assign pixValid   = pixValid_r;
    assign frameDone  = frameDone_r;
    assign scanActive = scanActive_r;
endmodule

// file: lsst_link_checker.sv
`timescale 1ns/1ps
// Watches the link between the two ends and checks its timing.
module lsst_link_checker #(
    parameter logic [lsst_pkg::CNT_W-1:0] MAX_CYCLE = lsst_pkg::MAX_CYCLE_CLKS
) (
    // Clock and reset.
    input  wire logic                         sys_clk,
    input  wire logic                         rst_n,
    // Link signals.
    input  wire logic                         scanStart,
    input  wire logic                         pixClk,
    input  wire logic                         trigStrobe,
    input  wire logic [lsst_pkg::VIDEO_W-1:0] video,
    input  wire logic                         scanEnd
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    // Run lengths in sys_clk cycles. The low count starts saturated, so the
    // idle time before the first start never reads as a short low phase.
    logic [23:0] highCnt_r, highCnt_nxt, lowCnt_r, lowCnt_nxt;
    logic [15:0] trigCnt_r, trigCnt_nxt;
    always_comb begin
        highCnt_nxt = scanStart ? highCnt_r + 24'h000001 : 24'h000000;
        lowCnt_nxt  = scanStart ? 24'h000000 : lowCnt_r + {23'h0, ~&lowCnt_r};
        trigCnt_nxt = scanStart ? 16'h0000 : trigCnt_r + {15'h0, trigStrobe};
    end
    // Registers only; reset parks the low count at its ceiling.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            highCnt_r <= 24'h000000;
            lowCnt_r  <= 24'hffffff;
            trigCnt_r <= 16'h0000;
        end else begin
            highCnt_r <= highCnt_nxt;
            lowCnt_r  <= lowCnt_nxt;
            trigCnt_r <= trigCnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Multi-step behaviours.
    sequence s_first_trig;
        ##[1:6] trigStrobe;
    endsequence
    sequence s_end_pulse;
        scanEnd ##1 !scanEnd;
    endsequence

    property p_clk_rate;
        $past(rst_n) |-> pixClk != $past(pixClk);
    endproperty
    property p_start_on_fall;
        $changed(scanStart) |-> $fell(pixClk);
    endproperty
    property p_high_min;
        $fell(scanStart) |-> highCnt_r >= 24'h00000c;
    endproperty
    property p_cycle_max;
        $fell(scanStart) |-> highCnt_r + 24'h000068 <= {MAX_CYCLE[22:0], 1'b0};
    endproperty
    property p_low_min;
        $rose(scanStart) |-> lowCnt_r >= 24'h000068;
    endproperty
    property p_trig_single;
        trigStrobe |=> !trigStrobe;
    endproperty
    property p_video_steady;
        $fell(trigStrobe) |-> $stable(video);
    endproperty
    property p_first_trig;
        $fell(scanStart) |-> s_first_trig;
    endproperty
    property p_quiet_high;
        scanStart && $past(scanStart, 2) |-> !trigStrobe && !scanEnd;
    endproperty
    property p_end_count;
        $rose(scanEnd) |-> (trigCnt_r >= 16'h022f && trigCnt_r <= 16'h0231)
            ##1 s_end_pulse;
    endproperty

    a_clk_rate: assert property (p_clk_rate)
        else $error("pixel clock did not toggle");
    a_start_on_fall: assert property (p_start_on_fall)
        else $error("start changed off a pixel clock fall");
    a_high_min: assert property (p_high_min)
        else $error("start high too short");
    a_cycle_max: assert property (p_cycle_max)
        else $error("start high beyond the longest cycle");
    a_low_min: assert property (p_low_min)
        else $error("start low too short");
    a_trig_single: assert property (p_trig_single)
        else $error("strobe high longer than one cycle");
    a_video_steady: assert property (p_video_steady)
        else $error("video moved at the strobe fall");
    a_first_trig: assert property (p_first_trig)
        else $error("readout did not start after start fell");
    a_quiet_high: assert property (p_quiet_high)
        else $error("readout activity while integrating");
    a_end_count: assert property (p_end_count)
        else $error("end of scan at wrong strobe count or width");
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
// Runs both ends through scans and compares every captured pixel.
module tb_top;
    localparam logic [23:0] MAXC = 24'h000258;
    logic        sys_clk, rst_n, runEn, partialMode, faultStart;
    logic [23:0] integReq, cycleReq, ri;
    logic [11:0] pixData;
    logic [8:0]  pixIndex;
    logic        pixValid, frameDone, scanActive;
    logic [31:0] rng;
    logic [21:0] note;
    logic [21:0] notes[$];
    int          failures, checks_done, cycles;

    lsst_link_if link();
    lsst_link_if linkB();
    // The spare sensor shares the clock but gets a badly timed start.
    assign linkB.pixClk    = link.pixClk;
    assign linkB.scanStart = faultStart;
    lsst_controller #(.MAX_CYCLE(MAXC)) u_lsst_controller (
        .sys_clk(sys_clk), .rst_n(rst_n), .runEn(runEn),
        .partialMode(partialMode), .integReq(integReq), .cycleReq(cycleReq),
        .pixData(pixData), .pixIndex(pixIndex), .pixValid(pixValid),
        .frameDone(frameDone), .scanActive(scanActive), .link(link));
    lsst_sensor u_lsst_sensor (.sys_clk(sys_clk), .rst_n(rst_n), .link(link));
    lsst_sensor u_lsst_sensor_b (.sys_clk(sys_clk), .rst_n(rst_n),
        .link(linkB));
    lsst_link_checker #(.MAX_CYCLE(MAXC)) u_lsst_link_checker (
        .sys_clk(sys_clk), .rst_n(rst_n), .scanStart(link.scanStart),
        .pixClk(link.pixClk), .trigStrobe(link.trigStrobe),
        .video(link.video), .scanEnd(link.scanEnd));

    ////////////////////////////////////////////////////////////////////////
    // Clock, and a ceiling well above the expected run of about 3500 cycles.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            complete_run();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic complete_run();
        $display("Counts: checks=%0d mismatches=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Pixels are sampled mid-cycle so the capture edge has settled.
    always @(negedge sys_clk) begin
        if (rst_n && pixValid === 1'b1) begin
            if (notes.size() == 0) begin
                `CHK(pixValid, 1'b0)
            end else begin
                note = notes.pop_front();
                `CHK({frameDone, pixIndex, pixData}, note)
            end
        end
    end

    // One scan: clamp the request as the controller must, note every
    // pixel, measure the start high time, then stop after the frame.
    task automatic run_scan(input logic pm, input logic [23:0] ir,
                            input logic [23:0] cr);
        logic [23:0] h, c;
        int          n, k, p;
        h = (ir < 24'h000006) ? 24'h000006 : ir;
        c = (cr < 24'h00003a) ? 24'h00003a : cr;
        if (!pm && c < 24'h000234) c = 24'h000234;
        if (pm && c < 24'h00004f) c = 24'h00004f;
        if (c < h + 24'h000034) c = h + 24'h000034;
        if (c > MAXC) c = MAXC;
        if (h > c - 24'h000034) h = c - 24'h000034;
        n = pm ? 32 : 512;
        for (k = 0; k < n; k++) begin
            p = int'(h) * (16 + k % 16);
            notes.push_back({k == n - 1, 9'(k), (p > 4095) ? 12'hfff : 12'(p)});
        end
        @(posedge sys_clk);
        partialMode <= pm;
        integReq    <= ir;
        cycleReq    <= cr;
        runEn       <= 1'b1;
        k = 0;
        while (link.scanStart !== 1'b1 && k < 3000) begin
            @(negedge sys_clk);
            k++;
        end
        p = 0;
        while (link.scanStart === 1'b1 && p < 3000) begin
            @(negedge sys_clk);
            p++;
        end
        `CHK(p, 2 * int'(h))
        k = 0;
        while (notes.size() > 0 && k < 4000) begin
            @(negedge sys_clk);
            k++;
        end
        `CHK(notes.size(), 0)
        notes.delete();
        @(posedge sys_clk);
        runEn <= 1'b0;
        $display("Scan done: partial=%0d high=%0d cycle=%0d", pm, h, c);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        rst_n       = 1'b0;
        runEn       = 1'b0;
        partialMode = 1'b0;
        integReq    = 24'h000000;
        cycleReq    = 24'h000000;
        faultStart  = 1'b0;
        rng         = 32'h6f0a11b3;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        // Too short a high and too long a cycle are both pulled in.
        run_scan(1'b0, 24'h000002, 24'h0002bc);
        // Long exposure drives the video word into saturation.
        run_scan(1'b1, 24'h0000c8, 24'h00012c);
        repeat (6) begin
            rng = xs(rng);
            ri  = 24'h000006 + 24'(rng % 22);
            run_scan(1'b1, ri, ri + 24'h00005a + {20'h0, rng[19:16]});
        end
        // Spare sensor: a short low phase, then start returns high.
        @(posedge sys_clk);
        faultStart <= 1'b1;
        repeat (12) @(posedge sys_clk);
        faultStart <= 1'b0;
        begin : fault_seq
            int t;
            t = 0;
            repeat (40) begin
                @(negedge sys_clk);
                t += int'(linkB.trigStrobe === 1'b1);
            end
            `CHK(t inside {[18:20]}, 1'b1)
            @(posedge sys_clk);
            faultStart <= 1'b1;
            repeat (3) @(negedge sys_clk);
            t = 0;
            repeat (200) begin
                @(negedge sys_clk);
                t += int'(linkB.trigStrobe !== 1'b0 || linkB.scanEnd !== 1'b0);
            end
            `CHK(t, 0)
            $display("Short low test done");
        end
        complete_run();
    end
endmodule
